// ### rtl/btsc_pkg.sv
// constants for the tester status, interrupt mask and per-channel select block
package btsc_pkg;
   // register indexes; byte address is four times the index
   localparam logic [5:0] IDX_STATUS = 6'h26;
   localparam logic [5:0] IDX_MASK = 6'h27;
   localparam logic [5:0] IDX_POINTER = 6'h28;
   localparam logic [5:0] IDX_DATA_1_8 = 6'h29;
   localparam logic [5:0] IDX_DATA_9_16 = 6'h2A;
   localparam logic [5:0] IDX_DATA_17_24 = 6'h2B;
   localparam logic [5:0] IDX_DATA_25_32 = 6'h2C;
   localparam logic [5:0] IDX_REALTIME = 6'h3F;
   // bus widths and map sizes
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int REG_W = 8;
   localparam int NUM_FUNC = 8;
   localparam int NUM_SLOTS = 32;
   localparam int NUM_DATA_REGS = 4;
   // status and mask bit positions
   localparam int BIT_SYNC = 0;
   localparam int BIT_LOS = 1;
   localparam int BIT_ZEROS = 2;
   localparam int BIT_ONES = 3;
   localparam int BIT_ERR_OVF = 4;
   localparam int BIT_CNT_OVF = 5;
   localparam int BIT_ERR = 6;
   // pointer bit positions (function selects)
   localparam int SEL_TESTER_TX = 0;
   localparam int SEL_TX_FRACTIONAL = 1;
   localparam int SEL_PAYLOAD_ERR = 2;
   localparam int SEL_TX_HW_SIG = 3;
   localparam int SEL_TESTER_RX = 4;
   localparam int SEL_RX_FRACTIONAL = 5;
   localparam int SEL_RX_SIG_REINSERT = 6;
   localparam int SEL_RX_SIG_ONES = 7;
   // run lengths for all-ones, all-zeros and pattern lock
   localparam logic [5:0] RUN_LEN = 6'h20;
   // reset values
   localparam logic [7:0] RST_REG = 8'h00;
   localparam logic [31:0] RST_WORD = 32'h0000_0000;
   localparam logic [5:0] RST_RUN = 6'h00;
endpackage

// ### rtl/btsc_top.sv
// tester status/interrupt registers and per-channel function maps behind an avalon slave
// Operation
// - the bit-error event latches on a detected error only while the tester is in sync, read clears it.
// - the bit-counter overflow event latches on each overflow pulse, read clears it until the next one.
// - the error-counter overflow event latches on each overflow pulse, read clears it until the next one.
// - all-ones is declared after 32 ones in a row, its flag clears only after a zero, both edges report.
// - all-zeros is declared after 32 zeros in a row, its flag clears only after a one, both edges report.
// - sync loss rises when pattern search starts and its flag stays set after relock until read.
// - in-sync is declared after 32 consecutive matching bits, with events on entry and exit.
// - a live, unlatched copy of the in-sync state is readable in a separate information register.
// - mask bits for the three event flags pass them to the interrupt when one, block when zero, reset zero.
// - mask bits for the four conditions pass both edges of the condition when one, none when zero.
// - the pointer register holds one select bit per per-channel function, in the fixed bit order.
//
// Design decision made here: the Avalon-MM slave port.
`timescale 1ns/10ps
module btsc_top
(
   input wire logic clock,
   input wire logic nrst,
   input wire logic [btsc_pkg::ADDR_W-1:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [btsc_pkg::DATA_W-1:0] writedata,
   input wire logic [3:0] byteenable,
   output logic [btsc_pkg::DATA_W-1:0] readdata,
   output logic waitrequest,
   input wire logic rx_bit_valid,
   input wire logic rx_bit,
   input wire logic rx_bit_match,
   input wire logic search_start,
   input wire logic bit_error_detected,
   input wire logic bit_counter_overflow_event,
   input wire logic error_counter_overflow_event,
   output logic irq,
   output logic pattern_in_sync,
   output logic [btsc_pkg::NUM_FUNC*btsc_pkg::NUM_SLOTS-1:0] channel_maps
);

   // saturating run counter: restarts on a miss, holds at the run length
   function automatic logic [5:0] run_step(input logic [5:0] cnt, input logic hit);
      logic [5:0] res;
      res = btsc_pkg::RST_RUN;
      if (hit)
      begin
         res = (cnt == btsc_pkg::RUN_LEN) ? cnt : cnt + 6'h01;
      end
      return res;
   endfunction

   logic [5:0] ones_run;
   logic [5:0] zeros_run;
   logic [5:0] match_run;
   logic all_ones;
   logic all_zeros;
   logic searching;
   logic [btsc_pkg::REG_W-1:0] status;
   logic [btsc_pkg::REG_W-1:0] mask;
   logic [btsc_pkg::REG_W-1:0] pointer;
   logic [btsc_pkg::REG_W-1:0] reported;
   logic [5:0] next_ones_run;
   logic [5:0] next_zeros_run;
   logic [5:0] next_match_run;
   logic next_all_ones;
   logic next_all_zeros;
   logic next_searching;
   logic next_pattern_in_sync;
   logic [btsc_pkg::REG_W-1:0] next_status;
   logic [btsc_pkg::REG_W-1:0] next_mask;
   logic [btsc_pkg::REG_W-1:0] next_pointer;
   logic [btsc_pkg::REG_W-1:0] next_reported;
   logic [btsc_pkg::NUM_FUNC*btsc_pkg::NUM_SLOTS-1:0] next_channel_maps;
   logic [btsc_pkg::DATA_W-1:0] next_readdata;
   logic next_waitrequest;
   logic next_irq;
   logic [5:0] index;
   logic req;
   logic accept;
   logic wr_en;
   logic rd_done;

   // request decode; the access completes in the cycle waitrequest is low
   assign index = address[btsc_pkg::ADDR_W-1:2];
   assign req = read | write;
   assign accept = req & ~waitrequest;
   assign wr_en = accept & write & byteenable[0];
   assign rd_done = accept & read & (index == btsc_pkg::IDX_STATUS);

   // line monitors: runs of ones, zeros and pattern matches
   always_comb
   begin
      next_ones_run = ones_run;
      next_zeros_run = zeros_run;
      next_match_run = match_run;
      next_all_ones = all_ones;
      next_all_zeros = all_zeros;
      next_searching = searching;
      next_pattern_in_sync = pattern_in_sync;
      if (rx_bit_valid)
      begin
         next_ones_run = run_step(ones_run, rx_bit);
         next_zeros_run = run_step(zeros_run, ~rx_bit);
         next_all_ones = (next_ones_run == btsc_pkg::RUN_LEN);
         next_all_zeros = (next_zeros_run == btsc_pkg::RUN_LEN);
         if (searching)
         begin
            next_match_run = run_step(match_run, rx_bit_match);
            if (next_match_run == btsc_pkg::RUN_LEN)
            begin
               next_searching = 1'b0;
               next_pattern_in_sync = 1'b1;
            end
         end
      end
      // a new search drops lock at once and restarts the match run
      if (search_start)
      begin
         next_searching = 1'b1;
         next_pattern_in_sync = 1'b0;
         next_match_run = btsc_pkg::RST_RUN;
      end
   end

   always_ff @(posedge clock)
   begin
      if (!nrst)
      begin
         ones_run <= btsc_pkg::RST_RUN;
         zeros_run <= btsc_pkg::RST_RUN;
         match_run <= btsc_pkg::RST_RUN;
         all_ones <= 1'b0;
         all_zeros <= 1'b0;
         searching <= 1'b1;
         pattern_in_sync <= 1'b0;
      end
      else
      begin
         ones_run <= next_ones_run;
         zeros_run <= next_zeros_run;
         match_run <= next_match_run;
         all_ones <= next_all_ones;
         all_zeros <= next_all_zeros;
         searching <= next_searching;
         pattern_in_sync <= next_pattern_in_sync;
      end
   end

   // status flags: events latch, conditions latch on either edge
   always_comb
   begin
      logic [btsc_pkg::REG_W-1:0] set_bits;
      logic [btsc_pkg::REG_W-1:0] cond_now;
      logic [btsc_pkg::REG_W-1:0] clr_bits;
      set_bits = btsc_pkg::RST_REG;
      cond_now = btsc_pkg::RST_REG;
      clr_bits = btsc_pkg::RST_REG;
      set_bits[btsc_pkg::BIT_ERR] = bit_error_detected & pattern_in_sync;
      set_bits[btsc_pkg::BIT_CNT_OVF] = bit_counter_overflow_event;
      set_bits[btsc_pkg::BIT_ERR_OVF] = error_counter_overflow_event;
      set_bits[btsc_pkg::BIT_ONES] = next_all_ones ^ all_ones;
      set_bits[btsc_pkg::BIT_ZEROS] = next_all_zeros ^ all_zeros;
      set_bits[btsc_pkg::BIT_LOS] = (next_searching ^ searching) | search_start;
      set_bits[btsc_pkg::BIT_SYNC] = next_pattern_in_sync ^ pattern_in_sync;
      // a condition flag may not clear while its condition still holds
      cond_now[btsc_pkg::BIT_ONES] = all_ones;
      cond_now[btsc_pkg::BIT_ZEROS] = all_zeros;
      cond_now[btsc_pkg::BIT_LOS] = searching;
      cond_now[btsc_pkg::BIT_SYNC] = pattern_in_sync;
      // only bits already shown to software are cleared, so nothing slips past
      clr_bits = rd_done ? (reported & ~cond_now) : btsc_pkg::RST_REG;
      next_status = set_bits | (status & ~clr_bits);
      next_irq = |(next_status & mask);
   end

   always_ff @(posedge clock)
   begin
      if (!nrst)
      begin
         status <= btsc_pkg::RST_REG;
         irq <= 1'b0;
      end
      else
      begin
         status <= next_status;
         irq <= next_irq;
      end
   end

   // writable registers: mask, pointer and per-channel maps
   always_comb
   begin
      next_mask = mask;
      next_pointer = pointer;
      next_channel_maps = channel_maps;
      if (wr_en)
      begin
         unique case (index)
            btsc_pkg::IDX_MASK: next_mask = writedata[btsc_pkg::REG_W-1:0];
            btsc_pkg::IDX_POINTER: next_pointer = writedata[btsc_pkg::REG_W-1:0];
            btsc_pkg::IDX_DATA_1_8, btsc_pkg::IDX_DATA_9_16,
            btsc_pkg::IDX_DATA_17_24, btsc_pkg::IDX_DATA_25_32:
            begin
               // several selects write every selected map alike
               for (int f = 0; f < btsc_pkg::NUM_FUNC; f++)
               begin
                  if (pointer[f])
                  begin
                     next_channel_maps[f*btsc_pkg::NUM_SLOTS + 8*(index - btsc_pkg::IDX_DATA_1_8) +: 8] =
                        writedata[btsc_pkg::REG_W-1:0];
                  end
               end
            end
            default:
            begin
               next_mask = mask;
            end
         endcase
      end
   end

   always_ff @(posedge clock)
   begin
      if (!nrst)
      begin
         mask <= btsc_pkg::RST_REG;
         pointer <= btsc_pkg::RST_REG;
         channel_maps <= '0;
      end
      else
      begin
         mask <= next_mask;
         pointer <= next_pointer;
         channel_maps <= next_channel_maps;
      end
   end

   // bus answer: readdata is loaded while waitrequest is high, holds until the next access
   always_comb
   begin
      logic [btsc_pkg::REG_W-1:0] rd;
      rd = btsc_pkg::RST_REG;
      unique case (index)
         btsc_pkg::IDX_STATUS: rd = status;
         btsc_pkg::IDX_MASK: rd = mask;
         btsc_pkg::IDX_POINTER: rd = pointer;
         btsc_pkg::IDX_DATA_1_8, btsc_pkg::IDX_DATA_9_16,
         btsc_pkg::IDX_DATA_17_24, btsc_pkg::IDX_DATA_25_32:
         begin
            for (int f = 0; f < btsc_pkg::NUM_FUNC; f++)
            begin
               if (pointer[f])
               begin
                  rd = rd | channel_maps[f*btsc_pkg::NUM_SLOTS + 8*(index - btsc_pkg::IDX_DATA_1_8) +: 8];
               end
            end
         end
         btsc_pkg::IDX_REALTIME: rd = {7'h00, pattern_in_sync};
         default: rd = btsc_pkg::RST_REG;
      endcase
      next_waitrequest = ~(req & waitrequest);
      next_readdata = readdata;
      next_reported = reported;
      if (req & waitrequest)
      begin
         next_readdata = read ? {24'h000000, rd} : btsc_pkg::RST_WORD;
         next_reported = (read && index == btsc_pkg::IDX_STATUS) ? status : btsc_pkg::RST_REG;
      end
   end

   always_ff @(posedge clock)
   begin
      if (!nrst)
      begin
         readdata <= btsc_pkg::RST_WORD;
         waitrequest <= 1'b1;
         reported <= btsc_pkg::RST_REG;
      end
      else
      begin
         readdata <= next_readdata;
         waitrequest <= next_waitrequest;
         reported <= next_reported;
      end
   end

endmodule

// ### sim/btsc_checker.sv
// checker for the tester status block, bound to its top
`timescale 1ns/10ps
module btsc_checker
(
   input wire logic clock,
   input wire logic nrst,
   input wire logic [7:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   input wire logic [3:0] byteenable,
   input wire logic [31:0] readdata,
   input wire logic waitrequest,
   input wire logic rx_bit_valid,
   input wire logic rx_bit,
   input wire logic rx_bit_match,
   input wire logic search_start,
   input wire logic bit_error_detected,
   input wire logic bit_counter_overflow_event,
   input wire logic error_counter_overflow_event,
   input wire logic irq,
   input wire logic pattern_in_sync,
   input wire logic [255:0] channel_maps
);
   logic [7:0] mask_q;
   logic [7:0] ptr_q;
   logic wr_ok;
   // completed write with the low byte enabled
   assign wr_ok = write && !waitrequest && byteenable[0];
   // shadow mask and pointer, since only ports are visible here
   always_ff @(posedge clock)
   begin
      mask_q <= !nrst ? 8'h00 : (wr_ok && address[7:2] == btsc_pkg::IDX_MASK) ? writedata[7:0] : mask_q;
      ptr_q <= !nrst ? 8'h00 : (wr_ok && address[7:2] == btsc_pkg::IDX_POINTER) ? writedata[7:0] : ptr_q;
   end
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!nrst);
   chk_wait_once: assert property ((read || write) && waitrequest |=> !waitrequest)
      else $error("no bus answer");
   chk_wait_pulse: assert property (!waitrequest |=> waitrequest)
      else $error("wait low too long");
   chk_read_upper: assert property (!waitrequest |-> readdata[31:8] == 24'h000000)
      else $error("upper read bits set");
   chk_irq_event: assert property (bit_counter_overflow_event && mask_q[5] |-> ##2 irq)
      else $error("unmasked event gave no irq");
   chk_irq_masked: assert property (mask_q == 8'h00 && $past(mask_q) == 8'h00 |-> !irq)
      else $error("irq with all masked");
   chk_sync_drop: assert property (search_start |=> !pattern_in_sync)
      else $error("sync kept after search");
   chk_sync_cause: assert property ($rose(pattern_in_sync) |-> $past(rx_bit_valid && rx_bit_match))
      else $error("sync without match");
   chk_map_write: assert property (wr_ok && address[7:2] == btsc_pkg::IDX_DATA_1_8 && ptr_q == 8'h01
      |=> channel_maps[7:0] == $past(writedata[7:0]))
      else $error("map write lost");
   chk_map_hold: assert property (!(write && !waitrequest) |=> $stable(channel_maps))
      else $error("map changed without write");
   cover property ($rose(irq));
   cover property ($rose(pattern_in_sync));
   cover property (read && !waitrequest);
endmodule
bind btsc_top btsc_checker chk_i
(
   .clock(clock), .nrst(nrst), .address(address), .read(read), .write(write),
   .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
   .waitrequest(waitrequest), .rx_bit_valid(rx_bit_valid), .rx_bit(rx_bit),
   .rx_bit_match(rx_bit_match), .search_start(search_start), .bit_error_detected(bit_error_detected),
   .bit_counter_overflow_event(bit_counter_overflow_event),
   .error_counter_overflow_event(error_counter_overflow_event),
   .irq(irq), .pattern_in_sync(pattern_in_sync), .channel_maps(channel_maps)
);

// ### sim/tb_top.sv
// self-checking bench for the tester status block
`timescale 1ns/10ps
module tb_top;
   logic clock = 1'b0;
   logic nrst = 1'b0;
   logic [7:0] address = 8'h00;
   logic read = 1'b0;
   logic write = 1'b0;
   logic [31:0] writedata = 32'h0;
   logic [3:0] byteenable = 4'hF;
   logic [31:0] readdata;
   logic waitrequest;
   logic rx_bit_valid = 1'b0;
   logic rx_bit = 1'b0;
   logic rx_bit_match = 1'b0;
   logic [3:0] evt = 4'h0;
   logic irq;
   logic pattern_in_sync;
   logic [255:0] channel_maps;
   logic [255:0] exp_maps = 256'h0;
   logic [7:0] q;
   int errors = 0;
   int samples_checked = 0;
   // 200 MHz clock
   always #2.5 clock = ~clock;
   btsc_top dut
   (
      .clock(clock), .nrst(nrst), .address(address), .read(read), .write(write),
      .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
      .waitrequest(waitrequest), .rx_bit_valid(rx_bit_valid), .rx_bit(rx_bit),
      .rx_bit_match(rx_bit_match), .search_start(evt[0]), .bit_error_detected(evt[1]),
      .bit_counter_overflow_event(evt[2]), .error_counter_overflow_event(evt[3]),
      .irq(irq), .pattern_in_sync(pattern_in_sync), .channel_maps(channel_maps)
   );
   task summarize();
      $display("checks %0d errors %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task chk(input logic [7:0] g, input logic [7:0] e);
      samples_checked++;
      if (g !== e)
      begin
         errors++;
         $display("BAD t=%0t got %h exp %h", $time, g, e);
      end
   endtask
   // request held until waitrequest is sampled low, bounded wait
   task acc(input logic w, input logic [5:0] idx, input logic [7:0] d);
      int n;
      @(posedge clock);
      read <= !w;
      write <= w;
      address <= {idx, 2'b00};
      writedata <= {24'h000000, d};
      n = 0;
      do
         @(posedge clock);
      while (waitrequest !== 1'b0 && n++ < 100);
      if (n >= 100)
      begin
         errors++;
         $display("BAD t=%0t bus answer timeout", $time);
      end
      q = readdata[7:0];
      read <= 1'b0;
      write <= 1'b0;
   endtask
   task rd(input logic [5:0] idx, input logic [7:0] e);
      acc(1'b0, idx, 8'h00);
      chk(q, e);
   endtask
   task pulse(input logic [3:0] m);
      @(posedge clock);
      evt <= m;
      @(posedge clock);
      evt <= 4'h0;
   endtask
   // alt toggles the bit value so no run condition builds up
   task bits(input int n, input logic v, input logic m, input logic alt);
      for (int i = 0; i < n; i++)
      begin
         @(posedge clock);
         rx_bit_valid <= 1'b1;
         rx_bit <= v ^ (alt & i[0]);
         rx_bit_match <= m;
      end
      @(posedge clock);
      rx_bit_valid <= 1'b0;
   endtask
   // irq is registered on the same edge as status, so let it settle first
   task irq_is(input logic e);
      repeat (3) @(posedge clock);
      #1;
      chk({7'h00, irq}, {7'h00, e});
   endtask
   task t_reset();
      rd(btsc_pkg::IDX_STATUS, 8'h00);
      rd(btsc_pkg::IDX_MASK, 8'h00);
      rd(btsc_pkg::IDX_POINTER, 8'h00);
      rd(btsc_pkg::IDX_REALTIME, 8'h00);
      rd(6'h00, 8'h00);
   endtask
   task t_events();
      acc(1'b1, btsc_pkg::IDX_MASK, 8'h7F);
      @(posedge clock);
      byteenable <= 4'h0;
      acc(1'b1, btsc_pkg::IDX_MASK, 8'h00);
      byteenable <= 4'hF;
      rd(btsc_pkg::IDX_MASK, 8'h7F);
      pulse(4'h4);
      irq_is(1'b1);
      rd(btsc_pkg::IDX_STATUS, 8'h20);
      rd(btsc_pkg::IDX_STATUS, 8'h00);
      irq_is(1'b0);
      pulse(4'h8);
      rd(btsc_pkg::IDX_STATUS, 8'h10);
      pulse(4'h2);
      rd(btsc_pkg::IDX_STATUS, 8'h00);
      acc(1'b1, btsc_pkg::IDX_MASK, 8'h00);
      pulse(4'h4);
      irq_is(1'b0);
      rd(btsc_pkg::IDX_STATUS, 8'h20);
   endtask
   task t_runs();
      acc(1'b1, btsc_pkg::IDX_MASK, 8'h08);
      bits(31, 1'b1, 1'b0, 1'b0);
      rd(btsc_pkg::IDX_STATUS, 8'h00);
      bits(32, 1'b1, 1'b0, 1'b0);
      irq_is(1'b1);
      rd(btsc_pkg::IDX_STATUS, 8'h08);
      rd(btsc_pkg::IDX_STATUS, 8'h08);
      bits(32, 1'b0, 1'b0, 1'b0);
      rd(btsc_pkg::IDX_STATUS, 8'h0C);
      rd(btsc_pkg::IDX_STATUS, 8'h04);
      irq_is(1'b0);
      bits(1, 1'b1, 1'b0, 1'b0);
      rd(btsc_pkg::IDX_STATUS, 8'h04);
      rd(btsc_pkg::IDX_STATUS, 8'h00);
   endtask
   task t_sync();
      pulse(4'h1);
      rd(btsc_pkg::IDX_STATUS, 8'h02);
      bits(31, 1'b0, 1'b1, 1'b1);
      rd(btsc_pkg::IDX_REALTIME, 8'h00);
      bits(32, 1'b0, 1'b1, 1'b1);
      rd(btsc_pkg::IDX_REALTIME, 8'h01);
      chk({7'h00, pattern_in_sync}, 8'h01);
      pulse(4'h2);
      rd(btsc_pkg::IDX_STATUS, 8'h43);
      rd(btsc_pkg::IDX_STATUS, 8'h01);
      pulse(4'h1);
      rd(btsc_pkg::IDX_STATUS, 8'h03);
      rd(btsc_pkg::IDX_STATUS, 8'h02);
   endtask
   task t_maps();
      logic [7:0] v;
      logic [5:0] idx;
      for (int f = 0; f < 8; f++)
      begin
         v = 8'hA5 ^ f[7:0];
         idx = btsc_pkg::IDX_DATA_1_8 + 6'(f % 4);
         acc(1'b1, btsc_pkg::IDX_POINTER, 8'h01 << f);
         rd(btsc_pkg::IDX_POINTER, 8'h01 << f);
         acc(1'b1, idx, v);
         exp_maps[f * 32 + (f % 4) * 8 +: 8] = v;
         rd(idx, v);
      end
      acc(1'b1, btsc_pkg::IDX_POINTER, 8'h00);
      acc(1'b1, btsc_pkg::IDX_DATA_1_8, 8'hFF);
      rd(btsc_pkg::IDX_DATA_1_8, 8'h00);
      for (int i = 0; i < 32; i++)
         chk(channel_maps[i * 8 +: 8], exp_maps[i * 8 +: 8]);
   endtask
   // hang guard, far beyond the expected run
   initial
   begin
      #100000;
      errors++;
      $display("BAD t=%0t timeout", $time);
      summarize();
   end
   initial
   begin
      repeat (12) @(posedge clock);
      nrst <= 1'b1;
      t_reset();
      t_events();
      t_runs();
      t_sync();
      t_maps();
      summarize();
   end
endmodule
